/* logic/lcr_defines.svh */
`ifndef LCR_DEFINES_SVH
`define LCR_DEFINES_SVH

`define LCR_ADDR_W 8
`define LCR_ADDR_SET 8'he0
`define LCR_ADDR_CLR 8'he4

`define LCR_BIT_SRC 22
`define LCR_BIT_MASTER 21
`define LCR_BIT_CTEN 20
`define LCR_BIT_PHY 10
`define LCR_BIT_SID 9
`define LCR_BIT_LOCK 6

`define LCR_LIVE_MASK 32'h0070_0640
`define LCR_ZERO_WORD 32'h0000_0000

`define LCR_OFS_W 12
// 3072 ticks of the 24.576 MHz clock make one 125 us cycle
`define LCR_CYCLE_TICKS 12'hc00
`define LCR_OFS_LAST 12'hbff
`define LCR_OFS_ZERO 12'h000
`define LCR_OFS_ONE 12'h001

`define LCR_CTX_NUM 4

`endif

/* logic/lcr_pkg.sv */
package lcr_pkg;
	typedef struct packed {
		logic src;
		logic master;
		logic cten;
		logic phy;
		logic sid;
		logic lock;
	} lcr_ctrl_type;

	typedef struct packed {
		logic valid;
		logic [11:0] offset;
	} lcr_cyc_start_type;
endpackage : lcr_pkg

/* logic/lcr_cycle_timer.sv */
`include "lcr_defines.svh"

module lcr_cycle_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic enable,
	input wire logic ext_src,
	input wire logic ext_pulse,
	input wire logic tick,
	input wire logic load,
	input wire logic [`LCR_OFS_W-1:0] load_val,
	output logic [`LCR_OFS_W-1:0] offset,
	output logic rollover
);
	logic [`LCR_OFS_W-1:0] ofs_r;
	logic [`LCR_OFS_W-1:0] ofs_nxt;
	logic roll_r;
	logic roll_nxt;

	////////////////////////////////////////////////////////////////
	always_comb begin
		ofs_nxt = ofs_r;
		roll_nxt = 1'b0;
		if (enable) begin
			if (load) begin
				ofs_nxt = load_val;
			end else if (ext_src && ext_pulse) begin
				ofs_nxt = `LCR_OFS_ZERO;
				roll_nxt = 1'b1;
			end else if (tick && !ext_src && ofs_r == `LCR_OFS_LAST) begin
				ofs_nxt = `LCR_OFS_ZERO;
				roll_nxt = 1'b1;
			end else if (tick) begin
				// external mode counts on past 12'hbff without a rollover until the pin says otherwise
				ofs_nxt = ofs_r + `LCR_OFS_ONE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ofs_r <= `LCR_OFS_ZERO;
			roll_r <= 1'b0;
		end else if (ce) begin
			ofs_r <= ofs_nxt;
			roll_r <= roll_nxt;
		end
	end

	assign offset = ofs_r;
	assign rollover = roll_r;

	////////////////////////////////////////////////////////////////
	a_wrap_at_last: assert property (
		@(posedge clk) disable iff (rst)
		ce && enable && !ext_src && !load && tick && ofs_r == `LCR_OFS_LAST
		|=> ofs_r == `LCR_OFS_ZERO && roll_r)
		else $error("internal cycle did not wrap after 3072 ticks");

	a_hold_when_off: assert property (
		@(posedge clk) disable iff (rst)
		ce && !enable |=> $stable(ofs_r) && !roll_r)
		else $error("offset moved while timer disabled");

	a_ext_rolls: assert property (
		@(posedge clk) disable iff (rst)
		ce && enable && ext_src && ext_pulse && !load
		|=> roll_r && ofs_r == `LCR_OFS_ZERO)
		else $error("external indication did not roll timer");

	a_ext_only: assert property (
		@(posedge clk) disable iff (rst)
		ce && ext_src && !ext_pulse |=> !roll_r)
		else $error("rollover without external indication");
endmodule : lcr_cycle_timer

/* logic/lcr_link_control.sv */
// Added by the designer: the address-and-strobe port.
`include "lcr_defines.svh"

module lcr_link_control (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [`LCR_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic CYCLE_IN,
	input wire logic OVERLONG,
	input wire logic TICK,
	input wire logic AR_ENABLE,
	input wire lcr_pkg::lcr_cyc_start_type RX_CS,
	input wire logic [`LCR_CTX_NUM-1:0] ISO_WR,
	input wire logic ISO_WDATA,
	output logic [`LCR_CTX_NUM-1:0] ISO_TAG1,
	output lcr_pkg::lcr_ctrl_type CTRL,
	output logic ACCEPT_PHY,
	output logic ACCEPT_SID,
	output logic [`LCR_OFS_W-1:0] CYCLE_OFFSET,
	output logic ROLLOVER,
	output logic SEND_CS
);
	import lcr_pkg::*;

	function automatic logic addr_hit(input logic [`LCR_ADDR_W-1:0] a,
			input logic [`LCR_ADDR_W-1:0] target);
		addr_hit = (a == target);
	endfunction : addr_hit

	function automatic logic [31:0] pack_word(input lcr_ctrl_type c);
		logic [31:0] w;
		w = `LCR_ZERO_WORD;
		w[`LCR_BIT_SRC] = c.src;
		w[`LCR_BIT_MASTER] = c.master;
		w[`LCR_BIT_CTEN] = c.cten;
		w[`LCR_BIT_PHY] = c.phy;
		w[`LCR_BIT_SID] = c.sid;
		w[`LCR_BIT_LOCK] = c.lock;
		pack_word = w;
	endfunction : pack_word

	lcr_ctrl_type ctrl_r;
	lcr_ctrl_type ctrl_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ovl_prev_r;
	logic ovl_rise;
	logic set_wr;
	logic clr_wr;
	logic cyc_meta_r;
	logic cyc_sync_r;
	logic cyc_prev_r;
	logic ext_pulse;
	logic [`LCR_CTX_NUM-1:0] tag1_r;
	logic [`LCR_CTX_NUM-1:0] tag1_nxt;
	logic send_r;
	logic send_nxt;
	logic timer_roll;
	logic timer_load;
	logic [`LCR_OFS_W-1:0] timer_ofs;

	////////////////////////////////////////////////////////////////
	// register port
	// two addresses
	assign set_wr = WR && addr_hit(ADDR, `LCR_ADDR_SET);
	assign clr_wr = WR && addr_hit(ADDR, `LCR_ADDR_CLR);
	assign ovl_rise = OVERLONG && !ovl_prev_r;

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (set_wr) begin
			ctrl_nxt.src = ctrl_r.src | WDATA[`LCR_BIT_SRC];
			ctrl_nxt.cten = ctrl_r.cten | WDATA[`LCR_BIT_CTEN];
			ctrl_nxt.phy = ctrl_r.phy | WDATA[`LCR_BIT_PHY];
			ctrl_nxt.sid = ctrl_r.sid | WDATA[`LCR_BIT_SID];
			ctrl_nxt.lock = ctrl_r.lock | WDATA[`LCR_BIT_LOCK];
		end
		if (clr_wr) begin
			ctrl_nxt.src = ctrl_r.src & ~WDATA[`LCR_BIT_SRC];
			ctrl_nxt.cten = ctrl_r.cten & ~WDATA[`LCR_BIT_CTEN];
			ctrl_nxt.phy = ctrl_r.phy & ~WDATA[`LCR_BIT_PHY];
			ctrl_nxt.sid = ctrl_r.sid & ~WDATA[`LCR_BIT_SID];
		end
		// the hardware clear beats a software set in the same cycle
		// overlong clears master
		if (ovl_rise) begin
			ctrl_nxt.master = 1'b0;
		end else if (set_wr && WDATA[`LCR_BIT_MASTER] && !OVERLONG) begin
			ctrl_nxt.master = 1'b1;
		end else if (clr_wr && WDATA[`LCR_BIT_MASTER]) begin
			ctrl_nxt.master = 1'b0;
		end
	end

	always_comb begin
		rdata_nxt = `LCR_ZERO_WORD;
		if (RD && (addr_hit(ADDR, `LCR_ADDR_SET) || addr_hit(ADDR, `LCR_ADDR_CLR))) begin
			rdata_nxt = pack_word(ctrl_r) & `LCR_LIVE_MASK;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_r <= '0;
			rdata_r <= `LCR_ZERO_WORD;
			ovl_prev_r <= 1'b0;
		end else if (CE) begin
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
			ovl_prev_r <= OVERLONG;
		end
	end

	////////////////////////////////////////////////////////////////
	// external cycle pin, two stages before any use
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cyc_meta_r <= 1'b0;
			cyc_sync_r <= 1'b0;
			cyc_prev_r <= 1'b0;
		end else if (CE) begin
			cyc_meta_r <= CYCLE_IN;
			cyc_sync_r <= cyc_meta_r;
			cyc_prev_r <= cyc_sync_r;
		end
	end

	assign ext_pulse = cyc_sync_r && !cyc_prev_r;

	////////////////////////////////////////////////////////////////
	// cycle timer
	// slave sync
	assign timer_load = RX_CS.valid && !ctrl_r.master;

	lcr_cycle_timer u_timer (
		.clk(MCLK),
		.rst(RST),
		.ce(CE),
		.enable(ctrl_r.cten),
		.ext_src(ctrl_r.src),
		.ext_pulse(ext_pulse),
		.tick(TICK),
		.load(timer_load),
		.load_val(RX_CS.offset),
		.offset(timer_ofs),
		.rollover(timer_roll)
	);

	always_comb begin
		send_nxt = timer_roll && ctrl_r.master;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			send_r <= 1'b0;
		end else if (CE) begin
			send_r <= send_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// tag-one sync filter bit of each receive context
	// writes while locked are dropped; the lock clears only on reset, which also zeroes the bits
	generate
		for (genvar i = 0; i < `LCR_CTX_NUM; i++) begin : g_ctx
			always_comb begin
				tag1_nxt[i] = tag1_r[i];
				if (ISO_WR[i] && !ctrl_r.lock) begin
					tag1_nxt[i] = ISO_WDATA;
				end
			end

			always_ff @(posedge MCLK or posedge RST) begin
				if (RST) begin
					tag1_r[i] <= 1'b0;
				end else if (CE) begin
					tag1_r[i] <= tag1_nxt[i];
				end
			end

			assign ISO_TAG1[i] = tag1_r[i] || ctrl_r.lock;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	assign RDATA = rdata_r;
	assign CTRL = ctrl_r;
	assign ACCEPT_PHY = ctrl_r.phy && AR_ENABLE;
	assign ACCEPT_SID = ctrl_r.sid;
	assign CYCLE_OFFSET = timer_ofs;
	assign ROLLOVER = timer_roll;
	assign SEND_CS = send_r;

	////////////////////////////////////////////////////////////////
	a_reserved_zero: assert property (
		@(posedge MCLK) disable iff (RST)
		(RDATA & ~`LCR_LIVE_MASK) == `LCR_ZERO_WORD)
		else $error("reserved bits read nonzero");

	a_read_back: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && RD && addr_hit(ADDR, `LCR_ADDR_CLR)
		|=> RDATA == (pack_word($past(ctrl_r)) & `LCR_LIVE_MASK))
		else $error("read does not return register contents");

	a_set_read: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && RD && addr_hit(ADDR, `LCR_ADDR_SET)
		|=> RDATA == (pack_word($past(ctrl_r)) & `LCR_LIVE_MASK))
		else $error("set address read does not return contents");

	a_read_idle: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && !RD |=> RDATA == `LCR_ZERO_WORD)
		else $error("read data present without a read");

	a_set_write: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && set_wr && WDATA[`LCR_BIT_CTEN] |=> ctrl_r.cten)
		else $error("set write did not set the bit");

	a_clear_write: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && clr_wr && WDATA[`LCR_BIT_SRC] |=> !ctrl_r.src)
		else $error("clear write did not clear the bit");

	a_zero_keeps: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && set_wr && !WDATA[`LCR_BIT_PHY] |=> ctrl_r.phy == $past(ctrl_r.phy))
		else $error("written zero changed a bit");

	a_master_drop: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && OVERLONG && !ovl_prev_r |=> !ctrl_r.master)
		else $error("overlong event did not clear master role");

	a_master_block: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && OVERLONG && !ctrl_r.master |=> !ctrl_r.master)
		else $error("master role set during overlong event");

	a_lock_sticky: assert property (
		@(posedge MCLK) disable iff (RST)
		ctrl_r.lock |=> ctrl_r.lock [*2])
		else $error("filter lock cleared without reset");

	a_lock_clear_ignored: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && clr_wr && WDATA[`LCR_BIT_LOCK] && ctrl_r.lock |=> ctrl_r.lock)
		else $error("clear address removed the filter lock");

	a_lock_force: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && set_wr && WDATA[`LCR_BIT_LOCK] |=> &ISO_TAG1)
		else $error("filter lock did not force tag-one bits");

	a_iso_write: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && !ctrl_r.lock && ISO_WR[0]
		|=> ctrl_r.lock || ISO_TAG1[0] == $past(ISO_WDATA))
		else $error("unlocked tag-one bit not writable");

	a_phy_gate: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && set_wr && WDATA[`LCR_BIT_PHY] && !ovl_rise
		|=> AR_ENABLE == ACCEPT_PHY)
		else $error("phy packet accept not following context");

	a_sid_alone: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && clr_wr && WDATA[`LCR_BIT_PHY] && !WDATA[`LCR_BIT_SID]
		|=> ACCEPT_SID == $past(ctrl_r.sid))
		else $error("phy packet bit changed self-id receipt");

	a_sid_set: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && set_wr && WDATA[`LCR_BIT_SID] |=> ACCEPT_SID)
		else $error("self-id receipt not enabled by set write");

	a_cycle_start: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && timer_roll && ctrl_r.master |=> SEND_CS)
		else $error("rollover as master sent no cycle start");

	a_slave_load: assert property (
		@(posedge MCLK) disable iff (RST)
		CE && ctrl_r.cten && !ctrl_r.master && RX_CS.valid
		|=> CYCLE_OFFSET == $past(RX_CS.offset))
		else $error("received cycle start did not resync offset");
endmodule : lcr_link_control

/* test/lcr_link_control_bench.sv */
`include "lcr_defines.svh"

module lcr_link_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lcr_pkg::*;

	logic mclk, rst, ce, wr, rd, cyc_in, overlong, tick, ar_en, iso_wdata, found;
	logic acc_phy, acc_sid, roll, send_cs;
	logic [7:0] addr, a;
	logic [31:0] wdata, rdata, got, model, d;
	logic [3:0] iso_wr, iso_tag1;
	logic [11:0] ofs;
	lcr_cyc_start_type rx_cs;
	lcr_ctrl_type ctrl;
	integer seed, error_cnt, n_tests, cyc, i;

	lcr_link_control u_dut (.MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CYCLE_IN(cyc_in), .OVERLONG(overlong), .TICK(tick),
		.AR_ENABLE(ar_en), .RX_CS(rx_cs), .ISO_WR(iso_wr), .ISO_WDATA(iso_wdata),
		.ISO_TAG1(iso_tag1), .CTRL(ctrl), .ACCEPT_PHY(acc_phy), .ACCEPT_SID(acc_sid),
		.CYCLE_OFFSET(ofs), .ROLLOVER(roll), .SEND_CS(send_cs));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			error_cnt++;
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] wa, input logic [31:0] wd);
		@(posedge mclk);
		addr <= wa;
		wdata <= wd;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] ra, output logic [31:0] rv);
		@(posedge mclk);
		addr <= ra;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		// taken at the next edge, before the flop drops it to zero
		@(posedge mclk);
		rv = rdata;
	endtask : rd_reg

	task automatic tick_n(input int n);
		repeat (n) begin
			@(posedge mclk);
			tick <= 1'b1;
		end
		@(posedge mclk);
		tick <= 1'b0;
		#1;
	endtask : tick_n

	// lock bit survives the clear address
	function automatic logic [31:0] next_model(logic [31:0] m, logic [7:0] wa, logic [31:0] wd);
		if (wa == `LCR_ADDR_SET) return m | (wd & `LCR_LIVE_MASK);
		if (wa == `LCR_ADDR_CLR) return m & ~(wd & `LCR_LIVE_MASK & ~32'h0000_0040);
		return m;
	endfunction : next_model

	// control outputs follow the register image bit for bit
	function automatic logic [5:0] exp_ctrl(logic [31:0] m);
		return {m[`LCR_BIT_SRC], m[`LCR_BIT_MASTER], m[`LCR_BIT_CTEN], m[`LCR_BIT_PHY],
			m[`LCR_BIT_SID], m[`LCR_BIT_LOCK]};
	endfunction : exp_ctrl

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h35179712;
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		{ce, wr, rd, cyc_in, overlong, tick, ar_en, iso_wdata} = 8'h80;
		addr = 8'h00;
		wdata = 32'h0;
		iso_wr = 4'h0;
		rx_cs = '0;
		rst = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(`LCR_ADDR_SET, got);
		chk(got, 32'h0);
		chk(ctrl, 32'h0);
		@(posedge mclk);
		iso_wr <= 4'h5;
		iso_wdata <= 1'b1;
		@(posedge mclk);
		iso_wr <= 4'h0;
		#1 chk(iso_tag1, 4'h5);
		wr_reg(`LCR_ADDR_SET, 32'h1 << `LCR_BIT_CTEN);
		@(posedge mclk);
		rx_cs <= '{1'b1, 12'hbfd};
		tick <= 1'b1;
		@(posedge mclk);
		rx_cs <= '0;
		tick <= 1'b0;
		#1 chk(ofs, 12'hbfd);
		tick_n(2);
		chk(ofs, 12'hbff);
		tick_n(1);
		chk({roll, ofs}, {1'b1, 12'h000});
		@(posedge mclk);
		#1 chk(send_cs, 1'b0);
		tick_n(5);
		wr_reg(`LCR_ADDR_CLR, 32'h1 << `LCR_BIT_CTEN);
		tick_n(3);
		chk(ofs, 12'h005);
		// master sends cycle start the cycle after the rollover, counting on from offset 5
		wr_reg(`LCR_ADDR_SET, 32'h0030_0000);
		tick_n(12'hbfa);
		chk(ofs, 12'hbff);
		tick_n(1);
		chk(roll, 1'b1);
		@(posedge mclk);
		#1 chk(send_cs, 1'b1);
		@(posedge mclk);
		overlong <= 1'b1;
		rd_reg(`LCR_ADDR_SET, got);
		chk(got[`LCR_BIT_MASTER], 1'b0);
		wr_reg(`LCR_ADDR_SET, 32'h1 << `LCR_BIT_MASTER);
		rd_reg(`LCR_ADDR_CLR, got);
		chk(got[`LCR_BIT_MASTER], 1'b0);
		overlong <= 1'b0;
		wr_reg(`LCR_ADDR_SET, 32'h1 << `LCR_BIT_MASTER | 32'h1 << `LCR_BIT_SRC);
		rd_reg(`LCR_ADDR_SET, got);
		chk(got, 32'h0070_0000);
		@(posedge mclk);
		tick <= 1'b1;
		cyc_in <= 1'b1;
		found = 1'b0;
		for (i = 0; i < 8 && !found; i++) begin
			@(posedge mclk);
			#1 found = (roll === 1'b1);
		end
		chk(found, 1'b1);
		chk(ofs, 12'h000);
		@(posedge mclk);
		tick <= 1'b0;
		cyc_in <= 1'b0;
		wr_reg(`LCR_ADDR_SET, 32'h1 << `LCR_BIT_PHY);
		for (i = 0; i < 4; i++) begin
			wr_reg(i[1] ? `LCR_ADDR_SET : `LCR_ADDR_CLR, 32'h1 << `LCR_BIT_SID);
			ar_en <= i[0];
			@(posedge mclk);
			#1 chk(acc_phy, i[0]);
			chk(acc_sid, i[1]);
		end
		wr_reg(`LCR_ADDR_SET, 32'h1 << `LCR_BIT_LOCK);
		@(posedge mclk);
		iso_wr <= 4'h2;
		iso_wdata <= 1'b0;
		@(posedge mclk);
		iso_wr <= 4'h0;
		#1 chk(iso_tag1, 4'hf);
		wr_reg(`LCR_ADDR_CLR, 32'hffff_ffff);
		model = 32'h0000_0040;
		for (i = 0; i < 48; i++) begin
			a = ($random(seed) & 1) ? `LCR_ADDR_SET : `LCR_ADDR_CLR;
			if (i % 8 == 7) a = 8'hec;
			d = $random(seed);
			wr_reg(a, d);
			model = next_model(model, a, d);
			rd_reg(($random(seed) & 1) ? `LCR_ADDR_SET : `LCR_ADDR_CLR, got);
			chk(got, model);
			chk(ctrl, exp_ctrl(model));
		end
		rd_reg(8'he8, got);
		chk(got, 32'h0);
		// a write strobe while frozen is lost
		ce <= 1'b0;
		wr_reg(`LCR_ADDR_SET, ~model);
		ce <= 1'b1;
		rd_reg(`LCR_ADDR_SET, got);
		chk(got, model);
		chk(ctrl, exp_ctrl(model));
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		rd_reg(`LCR_ADDR_SET, got);
		chk(got, 32'h0);
		chk(iso_tag1, 4'h0);
		finish_test();
	end
endmodule : lcr_link_control_bench
